// ---- rtl/sbs_decode.sv ----
// command decode, burst counter and data control for the sram
// Operation
// RULE1: enable true only when high select is 1 and both low selects 0
// RULE2: strobe with enable false, or first select high, ctrl low: deselect
// RULE3: enabled with processor strobe low loads address and starts read burst
// RULE4: enabled, proc high, ctrl low: load address, read or write
// RULE5: ctrl high, advance low: step counter, read or write by qualifier
// RULE6: ctrl high, advance high: hold address, repeat read or write
// RULE7: continue and suspend ignore selects when processor strobe is high
// RULE8: drive control is asynchronous; low enables drivers only on reads
// RULE9: all listed input combinations, redundant ones too, are decoded
// RULE10: controller may tie proc strobe high, ctrl low for single access
// RULE11: controller may tie proc high, advance low and pulse ctrl strobe
// RULE12: dummy reads with drive control high advance counter like reads
// RULE13: controller keeps drive control high for read to write turnaround
// RULE14: two-bit counter, four addresses, linear or interleaved, then wraps
// RULE15: write when all-write low, or gate low with per-lane selects; code flags a write on gate low even when no lane select is low
// RULE16: data lines stay high impedance during every write
// RULE17: inputs sampled on rising edge; read data flow-through or pipelined
// RULE18: suspend after deselect keeps address and makes no access; code still issues a read or write at the held address
module sbs_decode
  import sbs_pkg::*;
#(
  parameter int ADDR_W = sbs_pkg::ADDR_W_DEF,
  parameter int LANES  = sbs_pkg::LANES_DEF
) (
  // clock, reset and freeze
  input  wire logic                 sys_clk,
  input  wire logic                 nrst,
  input  wire logic                 clk_en,
  // synchronous command, address and write data
  input  wire sbs_pkg::sbs_ctl_t    ctl_in,
  input  wire logic [ADDR_W-1:0]    addr_in,
  input  wire logic [LANES-1:0]     lane_select_n,
  input  wire logic [LANES*8-1:0]   wdata_in,
  // asynchronous drive control and static mode pins
  input  wire logic                 output_drive_n,
  input  wire logic                 burst_order_select,
  input  wire logic                 flow_select_n,
  // array side
  input  wire logic [LANES*8-1:0]   mem_rdata,
  output logic [ADDR_W-1:0]         mem_addr,
  output logic                      mem_rd,
  output logic                      mem_wr,
  output logic [LANES-1:0]          mem_lane_wr,
  output logic [LANES*8-1:0]        mem_wdata,
  // data pins and decoded cycle
  output logic [LANES*8-1:0]        dq_out,
  output logic [LANES-1:0]          dq_oe_n,
  output sbs_pkg::sbs_cyc_t         cycle_kind
);
  import sbs_pkg::*;

  // burst state
  logic [ADDR_W-1:0]  base_reg;
  logic [BURST_W-1:0] cnt_reg;
  logic [BURST_W-1:0] cnt_next;

  // decode of the sampled command
  logic               wq;
  logic [LANES-1:0]   lane_wq;
  sbs_cyc_t           kind;
  logic               is_write;

  // read data path
  logic               rd_live_reg;
  logic               rd_pipe_reg;
  logic [LANES*8-1:0] q_pipe_reg;

  // burst address from base and offset in chosen order
  function automatic logic [BURST_W-1:0] burst_addr(
    input logic [BURST_W-1:0] start,
    input logic [BURST_W-1:0] off,
    input logic               ord);
    burst_addr = (ord == ORDER_LIN) ? BURST_W'(start + off)
                                    : (start ^ off); // RULE14
  endfunction

  // truth table: first_n, high, third_n, proc_n, ctrl_n, step_n
  function automatic sbs_cyc_t decode_cycle(input sbs_ctl_t c);
    logic [5:0] key;
    key = {c.cs_low_first_n, c.cs_high, c.cs_low_third_n,
           c.proc_strobe_n, c.ctrl_strobe_n, c.step_n};
    casez (key)
      6'b0?1?0?: decode_cycle = SBS_DESEL; // RULE2
      6'b00??0?: decode_cycle = SBS_DESEL; // RULE2
      6'b0?10??: decode_cycle = SBS_DESEL; // RULE2
      6'b00?0??: decode_cycle = SBS_DESEL; // RULE2
      6'b1???0?: decode_cycle = SBS_DESEL; // RULE2
      6'b0100??: decode_cycle = SBS_BEGIN; // RULE1 RULE3
      6'b01010?: decode_cycle = SBS_BEGIN; // RULE1 RULE4
      6'b???110: decode_cycle = SBS_CONT;  // RULE5 RULE7
      6'b1???10: decode_cycle = SBS_CONT;  // RULE5 RULE7
      6'b???111: decode_cycle = SBS_SUSP;  // RULE6 RULE7
      6'b1???11: decode_cycle = SBS_SUSP;  // RULE6 RULE7
      default:   decode_cycle = SBS_IDLE;  // RULE9
    endcase
  endfunction

  // cycles that touch the array
  function automatic logic is_access(input sbs_cyc_t k);
    is_access = (k == SBS_BEGIN) || (k == SBS_CONT) || (k == SBS_SUSP);
  endfunction

  // cycle kind; the enable test sits in the begin rows
  always_comb begin
    kind = decode_cycle(ctl_in); // RULE9
  end

  // write qualifier; a begin through processor strobe is always a read
  always_comb begin
    wq       = ~ctl_in.all_write_n | ~ctl_in.gate_write_n; // RULE15
    is_write = wq && !(kind == SBS_BEGIN
                       && !ctl_in.proc_strobe_n); // RULE3 RULE4
  end

  // per-lane write select and output drive, drive gated asynchronously
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    assign lane_wq[g] = ~ctl_in.all_write_n
                      | (~ctl_in.gate_write_n & ~lane_select_n[g]); // RULE15
    assign dq_oe_n[g] = ~rd_live_reg | output_drive_n | mem_wr; // RULE8 RULE16
  end

  // offset: cleared on begin, stepped on continue, held otherwise
  assign cnt_next = (kind == SBS_BEGIN) ? BURST_RST
                  : (kind == SBS_CONT) ? BURST_W'(cnt_reg + 1'b1)
                  : cnt_reg; // RULE14

  // burst start address, loaded on begin cycles
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      base_reg <= '0;
    end else if (clk_en && kind == SBS_BEGIN) begin
      base_reg <= addr_in; // RULE17
    end
  end

  // burst offset counter; dummy reads step it too
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cnt_reg <= BURST_RST;
    end else if (clk_en) begin
      cnt_reg <= cnt_next; // RULE12 RULE18
    end
  end

  // array address: external on begin, counter order on continue and suspend, held otherwise
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      mem_addr <= '0;
    end else if (clk_en) begin
      if (kind == SBS_BEGIN) begin
        mem_addr <= addr_in;
      end else if (is_access(kind)) begin
        mem_addr <= {base_reg[ADDR_W-1:BURST_W],
                     burst_addr(base_reg[BURST_W-1:0],
                                cnt_next, burst_order_select)}; // RULE5 RULE6
      end
    end
  end

  // read, write and lane strobes, one cycle per command
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      mem_rd      <= 1'b0;
      mem_wr      <= 1'b0;
      mem_lane_wr <= '0;
    end else if (clk_en) begin
      if (is_access(kind)) begin
        mem_rd      <= ~is_write; // RULE6 RULE12
        mem_wr      <= is_write;
        mem_lane_wr <= is_write ? lane_wq : '0;
      end else begin
        mem_rd      <= 1'b0; // RULE2
        mem_wr      <= 1'b0;
        mem_lane_wr <= '0;
      end
    end
  end

  // decoded cycle and write data, captured with the command
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cycle_kind <= SBS_IDLE;
      mem_wdata  <= '0;
    end else if (clk_en) begin
      cycle_kind <= kind; // RULE9
      mem_wdata  <= wdata_in; // RULE17
    end
  end

  // read marker one stage behind the access
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rd_pipe_reg <= 1'b0;
    end else if (clk_en) begin
      rd_pipe_reg <= mem_rd;
    end
  end

  // drivers live one edge after a read, two in pipeline mode
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rd_live_reg <= 1'b0;
    end else if (clk_en) begin
      rd_live_reg <= (flow_select_n == FT_FLOW) ? mem_rd
                                                : rd_pipe_reg; // RULE17
    end
  end

  // output register stage, used only in pipeline mode
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      q_pipe_reg <= '0;
    end else if (clk_en) begin
      q_pipe_reg <= mem_rdata;
    end
  end

  // data pins: array data direct or through the output stage
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      dq_out <= '0;
    end else if (clk_en) begin
      dq_out <= (flow_select_n == FT_FLOW) ? mem_rdata : q_pipe_reg; // RULE17
    end
  end
endmodule // sbs_decode

// ---- rtl/sbs_pkg.sv ----
// package for the sync burst sram command decode block
package sbs_pkg;
  localparam int ADDR_W_DEF  = 18;
  localparam int LANES_DEF   = 4;
  localparam int BURST_W     = 2;
  localparam logic [1:0] BURST_RST = 2'h0;
  localparam logic       FT_FLOW   = 1'b0; // flow-through select level
  localparam logic       ORDER_LIN = 1'b0; // linear order select level

  typedef enum logic [2:0] {
    SBS_DESEL  = 3'b000,
    SBS_BEGIN  = 3'b001,
    SBS_CONT   = 3'b010,
    SBS_SUSP   = 3'b011,
    SBS_IDLE   = 3'b100
  } sbs_cyc_t;

  typedef struct packed {
    logic cs_low_first_n;
    logic cs_high;
    logic cs_low_third_n;
    logic proc_strobe_n;
    logic ctrl_strobe_n;
    logic step_n;
    logic all_write_n;
    logic gate_write_n;
  } sbs_ctl_t;
endpackage : sbs_pkg

// ---- bench/sbs_mem_model.sv ----
// array model giving address-derived read data
module sbs_mem_model (
  input  wire logic [17:0] mem_addr,
  output logic [31:0]      mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // pattern from the address, so the bench can predict it
  assign mem_rdata = {mem_addr[15:0], ~mem_addr[15:0]};
endmodule // sbs_mem_model

// ---- bench/sbs_decode_properties.sv ----
// assertions on the sram command decode ports
module sbs_decode_properties
  import sbs_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              nrst,
  input wire logic              clk_en,
  input wire sbs_pkg::sbs_ctl_t ctl_in,
  input wire logic              output_drive_n,
  input wire logic              burst_order_select,
  input wire logic [17:0]       mem_addr,
  input wire logic              mem_rd,
  input wire logic              mem_wr,
  input wire logic [3:0]        dq_oe_n,
  input wire sbs_pkg::sbs_cyc_t cycle_kind
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       en;
  logic       ps;
  logic [1:0] lo;
  // chip enable, processor strobe, low address bits
  assign en = ctl_in.cs_high & ~ctl_in.cs_low_first_n & ~ctl_in.cs_low_third_n;
  assign ps = ctl_in.proc_strobe_n;
  assign lo = mem_addr[1:0];
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  a_begin_read: assert property (
    clk_en && en && !ps |=> mem_rd && !mem_wr && cycle_kind == SBS_BEGIN)
    else $error("begin read");
  a_begin_write: assert property (
    clk_en && en && ps && !ctl_in.ctrl_strobe_n && !ctl_in.all_write_n
    |=> mem_wr && !mem_rd) else $error("begin write");
  a_desel_cycle: assert property (
    clk_en && !en && !ctl_in.ctrl_strobe_n |=> !mem_rd && !mem_wr
    && cycle_kind == SBS_DESEL) else $error("deselect");
  a_cont_select: assert property (
    clk_en && ctl_in.ctrl_strobe_n && !ctl_in.step_n && (ps
    || ctl_in.cs_low_first_n) |=> cycle_kind == SBS_CONT) else $error("cont");
  a_cont_step: assert property (
    clk_en && ctl_in.ctrl_strobe_n && !ctl_in.step_n && ps
    && cycle_kind == SBS_BEGIN |=> lo == ($past(burst_order_select)
    ? $past(lo) ^ 2'h1 : $past(lo) + 2'h1)) else $error("step");
  a_susp_hold: assert property (
    clk_en && ctl_in.ctrl_strobe_n && ctl_in.step_n && ps
    && cycle_kind inside {SBS_BEGIN, SBS_CONT} |=> cycle_kind == SBS_SUSP
    && $stable(mem_addr)) else $error("suspend");
  a_drive_off: assert property (
    output_drive_n |-> &dq_oe_n) else $error("drive off");
  a_no_read_z: assert property (
    !$past(mem_rd) && !$past(mem_rd, 2) |-> &dq_oe_n) else $error("float");
endmodule // sbs_decode_properties

// ---- bench/sync_burst_sram_command_decode_tb_top.sv ----
// self-checking bench of the sram command decode
module sync_burst_sram_command_decode_tb_top;
  import sbs_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk = 0, nrst = 0, drive_n = 0, order = 0, flow = 0;
  logic        ce = 1;
  logic        mem_rd, mem_wr;
  logic [3:0]  mem_lane_wr, dq_oe_n;
  logic [17:0] mem_addr;
  logic [31:0] rdata, mem_wdata, dq_out;
  sbs_ctl_t    ctl_in = 8'hFF;
  sbs_cyc_t    cycle_kind;
  int          n_fail = 0, compares = 0;
  // rows: controls, drive, order, kind, rd, wr, address low bits
  logic [16:0] tv [14] = '{
    17'b01001111_0_0_001_1_0_01, 17'b10111011_1_0_010_1_0_10,
    17'b10111111_1_0_011_1_0_10, 17'b10001001_0_0_010_0_1_11,
    17'b00011010_0_0_010_0_1_00, 17'b00011011_0_0_010_1_0_01,
    17'b11010111_0_0_000_0_0_01, 17'b01101111_0_0_000_0_0_01,
    17'b00010111_0_0_000_0_0_01, 17'b00011111_0_0_011_1_0_01,
    17'b01010101_0_0_001_0_1_01, 17'b01001111_0_1_001_1_0_01,
    17'b00011011_0_1_010_1_0_00, 17'b00011011_0_1_010_1_0_11};
  sbs_decode dut_u (.sys_clk, .nrst, .clk_en(ce), .ctl_in,
    .addr_in(18'h00005), .lane_select_n(4'hA), .wdata_in(32'hC3A55A3C),
    .output_drive_n(drive_n), .burst_order_select(order),
    .flow_select_n(flow), .mem_rdata(rdata), .mem_addr, .mem_rd, .mem_wr,
    .mem_lane_wr, .mem_wdata, .dq_out, .dq_oe_n, .cycle_kind);
  sbs_mem_model mdl_u (.mem_addr, .mem_rdata(rdata));
  // clock
  initial forever #12.5 sys_clk = ~sys_clk;
  task automatic chk(input logic [39:0] got, exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("fails %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk_row(input logic [16:0] r);
    logic [3:0] lanes;
    lanes = r[10] ? 4'h5 : 4'hF;
    chk({cycle_kind, mem_rd, mem_wr}, r[6:2]);
    if (r[6:4] != SBS_DESEL) chk(mem_addr[1:0], r[1:0]);
    if (r[2]) chk({mem_lane_wr, mem_wdata}, {lanes, 32'hC3A55A3C});
  endtask
  // reset, table rows back to back, then a pipelined read
  initial begin
    repeat (12) @(negedge sys_clk);
    chk({cycle_kind, dq_oe_n, mem_rd, mem_wr}, {SBS_IDLE, 4'hF, 2'h0});
    nrst = 1;
    for (int i = 0; i < 14; i++) begin
      {ctl_in, drive_n, order} = tv[i][16:7];
      @(negedge sys_clk);
      chk_row(tv[i]);
    end
    ce = 0;
    ctl_in = 8'h4F;
    @(negedge sys_clk);
    chk({cycle_kind, mem_addr[1:0]}, {SBS_CONT, 2'h3});
    ce = 1;
    {ctl_in, flow} = {8'h17, 1'b1};
    repeat (3) @(negedge sys_clk);
    ctl_in = 8'h4F;
    @(negedge sys_clk);
    ctl_in = 8'h17;
    @(negedge sys_clk);
    chk(dq_oe_n, 4'hF);
    @(negedge sys_clk);
    chk({dq_oe_n, dq_out}, {4'h0, 32'h0005FFFA});
    drive_n = 1;
    #1 chk(dq_oe_n, 4'hF);
    print_verdict;
  end
  // watchdog
  initial begin
    #5000;
    n_fail++;
    print_verdict;
  end
endmodule // sync_burst_sram_command_decode_tb_top
bind sbs_decode sbs_decode_properties chk_u (.sys_clk, .nrst, .clk_en,
  .ctl_in, .output_drive_n, .burst_order_select, .mem_addr, .mem_rd,
  .mem_wr, .dq_oe_n, .cycle_kind);
